//--- core/pfc_defines.svh
// Constants for the per-function command control block
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH
`define PFC_NUM_FN 5
`define PFC_FN_LIMIT 3'h5
`define PFC_CMD_DWORD 6'h01
`define PFC_ADDR_DW_MSB 7
`define PFC_ADDR_DW_LSB 2
`define PFC_CMD_RESET 16'h0000
`define PFC_CMD_RW_MASK 16'h0567
`define PFC_STS_FIXED 16'h0210
`define PFC_STS_RESET 1'h0
`define PFC_BIT_IO 0
`define PFC_BIT_MEM 1
`define PFC_BIT_MAST 2
`define PFC_BIT_SPECIAL 3
`define PFC_BIT_MWI 4
`define PFC_BIT_PAL 5
`define PFC_BIT_PERR 6
`define PFC_BIT_RSVD7 7
`define PFC_BIT_SERR 8
`define PFC_BIT_B2B 9
`define PFC_BIT_INTDIS 10
`define PFC_RSVD_HI_MSB 15
`define PFC_RSVD_HI_LSB 11
`define PFC_STS_MDPE 8
`define PFC_STS_SSE 14
`endif

//--- core/pfc_pkg.sv
// Types shared by the command control modules
`include "pfc_defines.svh"
package pfc_pkg;
  typedef logic [15:0] pfc_half_t;
  typedef logic [31:0] pfc_word_t;
  typedef logic [`PFC_NUM_FN-1:0] pfc_fn_vec_t;
endpackage

//--- core/pfc_fn_if.sv
// Per-function link between the config decoder and the register copies
interface pfc_fn_if;
  import pfc_pkg::*;
  logic wr;
  logic [3:0] be;
  pfc_word_t wdata;
  pfc_half_t cmd_q;
  pfc_half_t sts_q;
  logic mdpe_set;
  logic sse_set;
  modport ctl (output wr, be, wdata, mdpe_set, sse_set, input cmd_q, sts_q);
  modport cmd (input wr, be, wdata, output cmd_q);
  modport sts (input wr, be, wdata, mdpe_set, sse_set, output sts_q);
endinterface

//--- core/pfc_cmd_reg.sv
// One function's copy of the command control register
`include "pfc_defines.svh"
module pfc_cmd_reg (
  input wire logic clock,
  input wire logic rst_n,
  pfc_fn_if.cmd fn
);
  import pfc_pkg::*;
  pfc_half_t cmd_reg;
  pfc_half_t cmd_next;

  // Mask keeps reserved and unsupported bits at zero whatever is written
  always_comb
  begin
    cmd_next = cmd_reg;
    if (fn.wr)
    begin
      if (fn.be[0])
        cmd_next[7:0] = fn.wdata[7:0];
      if (fn.be[1])
        cmd_next[15:8] = fn.wdata[15:8];
    end
    cmd_next = cmd_next & `PFC_CMD_RW_MASK; // RULE3 RULE5 RULE8 RULE12 RULE13
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cmd_reg <= `PFC_CMD_RESET; // RULE19
    else
      cmd_reg <= cmd_next; // RULE1
  end

  assign fn.cmd_q = cmd_reg;

  AST_RSVD_HI_ZERO: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
    fn.wr && fn.be[1] |=> cmd_reg[`PFC_RSVD_HI_MSB:`PFC_RSVD_HI_LSB] == 5'h00)
    else $error("reserved high command bits read nonzero");
  AST_RO_BITS_ZERO: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    fn.wr |=> !(cmd_reg[`PFC_BIT_B2B] || cmd_reg[`PFC_BIT_RSVD7] ||
      cmd_reg[`PFC_BIT_MWI] || cmd_reg[`PFC_BIT_SPECIAL]))
    else $error("hard-wired command bit read as one");
  AST_WRITE_TAKES: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
    fn.wr && fn.be[0] |=> cmd_reg[`PFC_BIT_IO] == $past(fn.wdata[`PFC_BIT_IO]))
    else $error("io enable did not follow write");
endmodule // pfc_cmd_reg

//--- core/pfc_err_status.sv
// One function's error flags in the upper status half
`include "pfc_defines.svh"
module pfc_err_status (
  input wire logic clock,
  input wire logic rst_n,
  pfc_fn_if.sts fn
);
  import pfc_pkg::*;
  logic mdpe_reg;
  logic mdpe_next;
  logic sse_reg;
  logic sse_next;
  logic clr_hi;

  // Both flags sit in lane 3; a set in the clearing cycle still wins
  assign clr_hi = fn.wr && fn.be[3];
  assign mdpe_next = (mdpe_reg && !(clr_hi && fn.wdata[16 + `PFC_STS_MDPE])) ||
    fn.mdpe_set;
  assign sse_next = (sse_reg && !(clr_hi && fn.wdata[16 + `PFC_STS_SSE])) || fn.sse_set;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdpe_reg <= `PFC_STS_RESET;
      sse_reg <= `PFC_STS_RESET;
    end
    else
    begin
      mdpe_reg <= mdpe_next; // RULE17
      sse_reg <= sse_next; // RULE18
    end
  end

  always_comb
  begin
    fn.sts_q = `PFC_STS_FIXED;
    fn.sts_q[`PFC_STS_MDPE] = mdpe_reg;
    fn.sts_q[`PFC_STS_SSE] = sse_reg;
  end

  AST_MDPE_SET: assert property (@(posedge clock) disable iff (!rst_n) // RULE17
    fn.mdpe_set |=> mdpe_reg)
    else $error("master data parity flag not set");
  AST_SSE_SET: assert property (@(posedge clock) disable iff (!rst_n) // RULE18
    fn.sse_set |=> sse_reg)
    else $error("signalled system error flag not set");
  AST_SSE_CAUSE: assert property (@(posedge clock) disable iff (!rst_n) // RULE18
    $rose(sse_reg) |-> $past(fn.sse_set))
    else $error("system error flag set without cause");
endmodule // pfc_err_status

//--- core/pfc_cmd_ctrl.sv
// Command control for five functions: config access, decode and error gating
// Functional notes
// RULE1: Five independent command copies, one per function
// RULE2: Error enables stored per function, used ORed
// RULE3: Bits fifteen to eleven always read zero
// RULE4: Interrupt disable bit blocks INTx assertion
// RULE5: Back-to-back enable reads zero, never used
// RULE6: System error enable gates SERR driver
// RULE7: Address parity reported needs both enables
// RULE8: Bit seven always reads zero
// RULE9: Parity response off ignores parity errors
// RULE10: Data parity uses PERR, address uses SERR
// RULE11: Palette snoop: no claim, capture data
// RULE12: No write-and-invalidate; plain memory writes only
// RULE13: Special cycles never answered, bit zero
// RULE14: Bus request only with initiator enable
// RULE15: Memory cycles claimed only when enabled
// RULE16: I/O cycles claimed only when enabled
// RULE17: Master parity flag needs parity response
// RULE18: System error flag needs SERR actually driven
// RULE19: Reset clears every writable control bit
`include "pfc_defines.svh"
module pfc_cmd_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [2:0] cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire pfc_pkg::pfc_word_t cfg_wdata,
  output pfc_pkg::pfc_word_t cfg_rdata,
  output logic cfg_rvalid,
  input wire pfc_pkg::pfc_fn_vec_t io_hit,
  input wire pfc_pkg::pfc_fn_vec_t mem_hit,
  input wire pfc_pkg::pfc_fn_vec_t pal_wr_hit,
  input wire pfc_pkg::pfc_word_t pal_wdata,
  input wire pfc_pkg::pfc_fn_vec_t master_req,
  input wire pfc_pkg::pfc_fn_vec_t master_active,
  input wire pfc_pkg::pfc_fn_vec_t int_pending,
  input wire logic special_cycle_hit,
  input wire logic addr_par_err,
  input wire logic data_par_err,
  input wire logic perr_seen,
  output pfc_pkg::pfc_fn_vec_t io_claim,
  output pfc_pkg::pfc_fn_vec_t mem_claim,
  output pfc_pkg::pfc_fn_vec_t pal_capture,
  output pfc_pkg::pfc_word_t pal_data,
  output pfc_pkg::pfc_fn_vec_t bus_req,
  output logic mwi_cmd_use,
  output logic special_claim,
  output pfc_pkg::pfc_fn_vec_t intx_assert,
  output logic serr_o,
  output logic serr_oe,
  output logic perr_o,
  output logic perr_oe,
  output logic system_error_drive_enable_any,
  output logic parity_response_enable_any
);
  import pfc_pkg::*;

  logic cfg_hit;
  logic [`PFC_NUM_FN-1:0][15:0] cmd_q_vec;
  logic [`PFC_NUM_FN-1:0][15:0] sts_q_vec;
  pfc_fn_vec_t io_en_vec;
  pfc_fn_vec_t mem_en_vec;
  pfc_fn_vec_t initiator_enable_vec;
  pfc_fn_vec_t pal_en_vec;
  pfc_fn_vec_t parity_response_enable_vec;
  pfc_fn_vec_t system_error_drive_enable_vec;
  pfc_fn_vec_t intdis_vec;
  pfc_fn_vec_t pal_snoop_vec;
  pfc_fn_vec_t mdpe_set_vec;
  pfc_fn_vec_t sse_set_vec;
  logic serr_eff;
  logic perr_eff;
  logic perr_any_seen;
  pfc_word_t rdata_next;

  pfc_word_t cfg_rdata_reg;
  logic cfg_rvalid_reg;
  pfc_fn_vec_t io_claim_reg;
  pfc_fn_vec_t mem_claim_reg;
  pfc_fn_vec_t pal_capture_reg;
  pfc_word_t pal_data_reg;
  pfc_fn_vec_t bus_req_reg;
  logic mwi_cmd_use_reg;
  logic special_claim_reg;
  pfc_fn_vec_t intx_reg;
  logic serr_oe_reg;
  logic perr_oe_reg;
  logic system_error_drive_enable_any_reg;
  logic parity_response_enable_any_reg;

  pfc_fn_if fn_bus [`PFC_NUM_FN] ();

  // Only dword 04h of an existing function belongs to this block
  assign cfg_hit = (cfg_addr[`PFC_ADDR_DW_MSB:`PFC_ADDR_DW_LSB] == `PFC_CMD_DWORD) &&
    (cfg_func < `PFC_FN_LIMIT);

  genvar g;
  generate
    for (g = 0; g < `PFC_NUM_FN; g++)
    begin : g_fn
      assign fn_bus[g].wr = cfg_wr && cfg_hit && (cfg_func == 3'(g)); // RULE1
      assign fn_bus[g].be = cfg_be;
      assign fn_bus[g].wdata = cfg_wdata;
      assign fn_bus[g].mdpe_set = mdpe_set_vec[g];
      assign fn_bus[g].sse_set = sse_set_vec[g];
      assign cmd_q_vec[g] = fn_bus[g].cmd_q;
      assign sts_q_vec[g] = fn_bus[g].sts_q;
      assign io_en_vec[g] = cmd_q_vec[g][`PFC_BIT_IO];
      assign mem_en_vec[g] = cmd_q_vec[g][`PFC_BIT_MEM];
      assign initiator_enable_vec[g] = cmd_q_vec[g][`PFC_BIT_MAST];
      assign pal_en_vec[g] = cmd_q_vec[g][`PFC_BIT_PAL];
      assign parity_response_enable_vec[g] = cmd_q_vec[g][`PFC_BIT_PERR];
      assign system_error_drive_enable_vec[g] = cmd_q_vec[g][`PFC_BIT_SERR];
      assign intdis_vec[g] = cmd_q_vec[g][`PFC_BIT_INTDIS];

      pfc_cmd_reg u_cmd (
        .clock(clock),
        .rst_n(rst_n),
        .fn(fn_bus[g])
      );

      pfc_err_status u_sts (
        .clock(clock),
        .rst_n(rst_n),
        .fn(fn_bus[g])
      );
    end
  endgenerate

  // Enables look separate to software but act as one across functions
  assign serr_eff = |system_error_drive_enable_vec; // RULE2
  assign perr_eff = |parity_response_enable_vec; // RULE2

  assign pal_snoop_vec = pal_wr_hit & pal_en_vec; // RULE11

  // Own PERR counts as seen too, so a master sees its own detection
  assign perr_any_seen = perr_seen || perr_oe_reg;
  assign mdpe_set_vec = {`PFC_NUM_FN{perr_any_seen}} & master_active & parity_response_enable_vec; // RULE17
  assign sse_set_vec = {`PFC_NUM_FN{serr_oe_reg}} & system_error_drive_enable_vec; // RULE18

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (cfg_rd && cfg_hit)
      rdata_next = {sts_q_vec[cfg_func], cmd_q_vec[cfg_func]}; // RULE3 RULE8
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_rdata_reg <= 32'h0000_0000;
      cfg_rvalid_reg <= 1'h0;
    end
    else
    begin
      cfg_rdata_reg <= rdata_next;
      cfg_rvalid_reg <= cfg_rd;
    end
  end

  // Target decode; a snooped palette write is never claimed
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_claim_reg <= '0;
      mem_claim_reg <= '0;
      special_claim_reg <= 1'h0;
    end
    else
    begin
      io_claim_reg <= io_hit & io_en_vec & ~pal_snoop_vec; // RULE16 RULE11
      mem_claim_reg <= mem_hit & mem_en_vec & ~pal_snoop_vec; // RULE15 RULE11
      special_claim_reg <= special_cycle_hit && 1'h0; // RULE13
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pal_capture_reg <= '0;
      pal_data_reg <= 32'h0000_0000;
    end
    else
    begin
      pal_capture_reg <= pal_snoop_vec; // RULE11
      if (|pal_snoop_vec)
        pal_data_reg <= pal_wdata; // RULE11
    end
  end

  // Initiator side: fast back-to-back and write-and-invalidate are never used
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_req_reg <= '0;
      mwi_cmd_use_reg <= 1'h0;
      intx_reg <= '0;
    end
    else
    begin
      bus_req_reg <= master_req & initiator_enable_vec; // RULE14
      mwi_cmd_use_reg <= 1'h0; // RULE12 RULE5
      intx_reg <= int_pending & ~intdis_vec; // RULE4
    end
  end

  // Error pins follow the gated error input one clock later; both drive low through their enables
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serr_oe_reg <= 1'h0;
      perr_oe_reg <= 1'h0;
      system_error_drive_enable_any_reg <= 1'h0;
      parity_response_enable_any_reg <= 1'h0;
    end
    else
    begin
      serr_oe_reg <= addr_par_err && serr_eff && perr_eff; // RULE6 RULE7 RULE10
      perr_oe_reg <= data_par_err && perr_eff; // RULE9 RULE10
      system_error_drive_enable_any_reg <= serr_eff;
      parity_response_enable_any_reg <= perr_eff;
    end
  end

  assign cfg_rdata = cfg_rdata_reg;
  assign cfg_rvalid = cfg_rvalid_reg;
  assign io_claim = io_claim_reg;
  assign mem_claim = mem_claim_reg;
  assign pal_capture = pal_capture_reg;
  assign pal_data = pal_data_reg;
  assign bus_req = bus_req_reg;
  assign mwi_cmd_use = mwi_cmd_use_reg;
  assign special_claim = special_claim_reg;
  assign intx_assert = intx_reg;
  assign serr_o = 1'h0;
  assign serr_oe = serr_oe_reg;
  assign perr_o = 1'h0;
  assign perr_oe = perr_oe_reg;
  assign system_error_drive_enable_any = system_error_drive_enable_any_reg;
  assign parity_response_enable_any = parity_response_enable_any_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_FN_ISOLATED: assert property ( // RULE1
    cfg_wr && cfg_hit && cfg_func == 3'h0 |=> $stable(cmd_q_vec[`PFC_NUM_FN-1:1]))
    else $error("write to function 0 changed another copy");
  AST_IO_GATED: assert property ( // RULE16
    (io_claim_reg & ~$past(io_en_vec)) == '0)
    else $error("io cycle claimed while disabled");
  AST_MEM_GATED: assert property ( // RULE15
    (mem_claim_reg & ~$past(mem_en_vec)) == '0)
    else $error("memory cycle claimed while disabled");
  AST_REQ_GATED: assert property ( // RULE14
    (bus_req_reg & ~$past(initiator_enable_vec)) == '0)
    else $error("bus requested without initiator enable");
  AST_INT_GATED: assert property ( // RULE4
    (intx_reg & $past(intdis_vec)) == '0)
    else $error("interrupt asserted while disabled");
  AST_SERR_CAUSE: assert property ( // RULE7
    serr_oe |-> $past(addr_par_err && serr_eff && perr_eff))
    else $error("system error driven without cause or enables");
  AST_SERR_ANY_FN: assert property ( // RULE2
    addr_par_err && (|system_error_drive_enable_vec[`PFC_NUM_FN-1:1]) && parity_response_enable_vec[0] |=> serr_oe)
    else $error("ORed error enables not honoured");
  AST_PERR_IGNORED: assert property ( // RULE9
    data_par_err && !perr_eff |=> !perr_oe)
    else $error("parity error answered while response off");
  AST_PERR_DRIVEN: assert property ( // RULE10
    data_par_err && perr_eff |=> perr_oe ##1 (perr_oe == $past(data_par_err && perr_eff)))
    else $error("data parity error not signalled on PERR");
  AST_SNOOP_NO_CLAIM: assert property ( // RULE11
    |pal_capture_reg |-> (pal_capture_reg & (io_claim_reg | mem_claim_reg)) == '0)
    else $error("snooped palette write was claimed");
  AST_NO_SPECIAL: assert property ( // RULE13
    !special_claim && !mwi_cmd_use)
    else $error("special cycle or invalidate command used");
  AST_RD_ANSWER: assert property (
    cfg_rd |=> cfg_rvalid)
    else $error("config read not answered");

  CV_IO_CLAIM: cover property (|io_claim_reg);
  CV_SERR: cover property (serr_oe_reg && sse_set_vec != '0);
  CV_PAL_SNOOP: cover property (|pal_capture_reg);
  CV_MDPE: cover property (|mdpe_set_vec);
endmodule // pfc_cmd_ctrl

//--- verif/pfc_bus_agent.sv
// Far-side stand-in: an arbiter that grants the bus to one requesting function
module pfc_bus_agent (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic stall,
  input wire pfc_pkg::pfc_fn_vec_t bus_req,
  output pfc_pkg::pfc_fn_vec_t master_active
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lowest requester wins; stall withholds the grant to model a slow arbiter
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      master_active <= 5'h00;
    else if (stall)
      master_active <= 5'h00;
    else
      master_active <= bus_req & (~bus_req + 5'h01);
  end
endmodule // pfc_bus_agent

//--- verif/testbench.sv
// Self-checking bench for the five-function command control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pfc_pkg::*;
  localparam pfc_half_t CMDS [5] = '{16'h0140, 16'h0100, 16'h0044, 16'h0000, 16'h0000};
  localparam pfc_half_t STS [5] = '{16'h4210, 16'h4210, 16'h0310, 16'h0210, 16'h0210};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_wr, cfg_rd, special_cycle_hit, addr_par_err, data_par_err, perr_seen, stall;
  logic [2:0] cfg_func, fn;
  logic [7:0] cfg_addr, ad;
  logic [3:0] cfg_be, be;
  pfc_word_t cfg_wdata, pal_wdata, cfg_rdata, pal_data, rd_val, d;
  pfc_fn_vec_t io_hit, mem_hit, pal_wr_hit, master_req, master_active, int_pending;
  pfc_fn_vec_t io_claim, mem_claim, pal_capture, bus_req, intx_assert;
  logic cfg_rvalid, mwi_cmd_use, special_claim, serr_o, serr_oe, perr_o, perr_oe;
  logic system_error_drive_enable_any, parity_response_enable_any;
  int error_cnt = 0;
  int check_count = 0;
  integer seed = 66083;
  pfc_half_t shadow [5];

  always #4 clock = ~clock;

  pfc_cmd_ctrl uut (.clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .io_hit(io_hit), .mem_hit(mem_hit),
    .pal_wr_hit(pal_wr_hit), .pal_wdata(pal_wdata), .master_req(master_req),
    .master_active(master_active), .int_pending(int_pending),
    .special_cycle_hit(special_cycle_hit), .addr_par_err(addr_par_err),
    .data_par_err(data_par_err), .perr_seen(perr_seen), .io_claim(io_claim),
    .mem_claim(mem_claim), .pal_capture(pal_capture), .pal_data(pal_data), .bus_req(bus_req),
    .mwi_cmd_use(mwi_cmd_use), .special_claim(special_claim), .intx_assert(intx_assert),
    .serr_o(serr_o), .serr_oe(serr_oe), .perr_o(perr_o), .perr_oe(perr_oe),
    .system_error_drive_enable_any(system_error_drive_enable_any), .parity_response_enable_any(parity_response_enable_any));

  pfc_bus_agent agent (.clock(clock), .rst_n(rst_n), .stall(stall), .bus_req(bus_req),
    .master_active(master_active));

  task automatic chk(input pfc_word_t got, input pfc_word_t exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Writable command bits are 10, 8, 6, 5, 2, 1, 0; everything else reads zero
  function automatic pfc_half_t upd(input pfc_half_t old, input logic [1:0] b, input pfc_half_t v);
    pfc_half_t m;
    m = {{8{b[1]}}, {8{b[0]}}} & 16'h0567;
    return (old & ~m) | (v & m);
  endfunction

  function automatic pfc_word_t exp_rd(input logic [2:0] f, input logic [7:0] a);
    return (f < 3'h5 && a[7:2] == 6'h01) ? {16'h0210, shadow[f]} : 32'h0000_0000;
  endfunction

  function automatic pfc_fn_vec_t en(input int b);
    pfc_fn_vec_t v;
    for (int f = 0; f < 5; f++)
      v[f] = shadow[f][b];
    return v;
  endfunction

  // Request raised after one edge, dropped after the taking edge; read data sampled 1 ns later
  task automatic cfg_op(input logic wr, input logic [2:0] f, input logic [7:0] a,
      input logic [3:0] b, input pfc_word_t v);
    @(posedge clock);
    cfg_wr <= wr;
    cfg_rd <= ~wr;
    cfg_func <= f;
    cfg_addr <= a;
    cfg_be <= b;
    cfg_wdata <= v;
    @(posedge clock);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    #1;
    if (!wr)
    begin
      chk({31'h0, cfg_rvalid}, 32'h1);
      rd_val = cfg_rdata;
    end
  endtask

  task automatic reset_check();
    shadow = '{default: 16'h0000};
    for (int f = 0; f < 8; f++)
    begin
      cfg_op(1'b0, f[2:0], 8'h04, 4'h0, 32'h0);
      chk(rd_val, exp_rd(f[2:0], 8'h04));
    end
  endtask

  task automatic gate_check();
    chk(io_claim, io_hit & en(0) & ~(pal_wr_hit & en(5)));
    chk(mem_claim, mem_hit & en(1) & ~(pal_wr_hit & en(5)));
    chk(pal_capture, pal_wr_hit & en(5));
    if (|(pal_wr_hit & en(5)))
      chk(pal_data, pal_wdata);
    chk(bus_req, master_req & en(2));
    chk(intx_assert, int_pending & ~en(10));
    chk({mwi_cmd_use, special_claim, serr_o, perr_o}, 4'h0);
    chk({system_error_drive_enable_any, parity_response_enable_any}, {|en(8), |en(6)});
    chk(serr_oe, addr_par_err & |en(8) & |en(6));
    chk(perr_oe, data_par_err & |en(6));
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    {cfg_wr, cfg_rd, cfg_func, cfg_addr, cfg_be, cfg_wdata, pal_wdata} = '0;
    {io_hit, mem_hit, pal_wr_hit, master_req, int_pending} = '0;
    {special_cycle_hit, addr_par_err, data_par_err, perr_seen, stall} = '0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    reset_check();
    $display("reset values done");
    for (int f = 0; f < 5; f++)
    begin
      cfg_op(1'b1, f[2:0], 8'h04, 4'h3, 32'hFFFF_FFFF);
      shadow[f] = 16'h0567;
      cfg_op(1'b0, f[2:0], 8'h04, 4'h0, 32'h0);
      chk(rd_val, 32'h0210_0567);
    end
    $display("read-only bits done");
    for (int i = 0; i < 30; i++)
    begin
      fn = 3'({$random(seed)} % 6);
      ad = ($random(seed) & 3) ? 8'h04 : 8'($random(seed));
      be = 4'($random(seed));
      d = $random(seed);
      cfg_op(1'b1, fn, ad, be, d);
      if (fn < 3'h5 && ad[7:2] == 6'h01)
        shadow[fn] = upd(shadow[fn], be[1:0], d[15:0]);
      fn = 3'({$random(seed)} % 6);
      cfg_op(1'b0, fn, ad, 4'h0, 32'h0);
      chk(rd_val, exp_rd(fn, ad));
    end
    $display("random access done");
    for (int i = 0; i < 60; i++)
    begin
      d = $random(seed);
      cfg_op(1'b1, 3'(i % 5), 8'h04, 4'h3, d);
      shadow[i % 5] = upd(shadow[i % 5], 2'h3, d[15:0]);
      @(posedge clock);
      {io_hit, mem_hit, pal_wr_hit, master_req, int_pending} <= 25'({$random(seed), $random(seed)});
      pal_wdata <= $random(seed);
      {special_cycle_hit, addr_par_err, data_par_err, perr_seen, stall} <= 5'($random(seed));
      @(posedge clock);
      #1;
      gate_check();
    end
    $display("decode gating done");
    @(posedge clock);
    {io_hit, mem_hit, pal_wr_hit, master_req, int_pending} <= '0;
    {special_cycle_hit, addr_par_err, data_par_err, perr_seen, stall} <= '0;
    // Let flags from the random phase settle so the clearing writes are not beaten by a set
    repeat (4) @(posedge clock);
    for (int f = 0; f < 5; f++)
    begin
      shadow[f] = CMDS[f];
      cfg_op(1'b1, f[2:0], 8'h04, 4'hF, {16'hFFFF, CMDS[f]});
    end
    @(posedge clock);
    master_req <= 5'h04;
    addr_par_err <= 1'b1;
    @(posedge clock);
    addr_par_err <= 1'b0;
    #1;
    chk(serr_oe, 1'b1);
    repeat (2) @(posedge clock);
    perr_seen <= 1'b1;
    @(posedge clock);
    perr_seen <= 1'b0;
    master_req <= 5'h00;
    repeat (3) @(posedge clock);
    for (int f = 0; f < 5; f++)
    begin
      cfg_op(1'b0, f[2:0], 8'h04, 4'h0, 32'h0);
      chk(rd_val, {STS[f], CMDS[f]});
    end
    $display("error flags done");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    reset_check();
    $display("mid-run reset done");
    test_done();
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    $display("ERROR t=%0t watchdog expired", $time);
    test_done();
  end
endmodule // testbench
